// *** eint_ctrl.sv ***
/*
  eint_ctrl: two external interrupt pins with edge or low-level sense,
  write-one-to-clear pending flags, vector requests and level wake-up.
  assumes the core presents i/o accesses by i/o offset, one per cycle,
  pulses ack when it enters a source's interrupt routine, and drives
  io_clk_run_i and power_down_i from its own sleep control.
*/
`timescale 1ns/1ps

module eint_ctrl #(
  parameter int            NSRC        = 2,
  parameter logic [15:0]   STARTUP_CYC = eint_pkg::STARTUP_CYC_RST
) (
  input  wire logic                 clk_i,          // core clock, 100 MHz
  input  wire logic                 rst_b_i,        // async reset, active low
  input  wire logic [NSRC-1:0]      pin_i,          // pin levels incl. own output drive
  input  wire logic [2*NSRC-1:0]    sense_i,        // two-bit sense code per source
  input  wire logic [NSRC-1:0]      src_en_i,       // per-source enables
  input  wire logic                 glob_en_i,      // global interrupt enable
  input  wire logic                 io_clk_run_i,   // i/o clock running
  input  wire logic                 power_down_i,   // core in deep sleep
  input  wire eint_pkg::eint_io_req_t io_req_i,     // i/o register access
  input  wire logic [NSRC-1:0]      ack_i,          // routine entered, per source
  output logic      [7:0]           io_rdata_o,     // read data
  output logic                      io_hit_o,       // access hits the flag register
  output logic      [NSRC-1:0]      vec_req_o,      // vector request per source
  output logic                      wake_o,         // wake the core
  output logic      [NSRC-1:0]      pending_o       // pending flags as read
);

  // ****************************************
  // synchronisers and sense
  // ****************************************
  logic [NSRC-1:0] sync1_r;
  logic [NSRC-1:0] sync2_r;
  logic [NSRC-1:0] prev_r;
  logic [NSRC-1:0] pend_r;
  logic [NSRC-1:0] is_level;
  logic [NSRC-1:0] edge_hit;
  logic [NSRC-1:0] clr_wr;
  logic [NSRC-1:0] lvl_ok_r;

  // the pin input is read back from the pad, so own drive counts
  // both stages reset to the idle-high level so release fakes no fall
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // edge history
  // ****************************************
  // history only advances while the i/o clock runs; a change made while
  // it is stopped shows up as an edge once it runs again
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prev_r <= '1;
    else if (io_clk_run_i)
      prev_r <= sync2_r;
  end

  // ****************************************
  // flag clear decode
  // ****************************************
  // ones clear and zeros keep, so one source can be cleared without a
  // read-modify-write that could lose the other source's fresh event
  always_comb
  begin
    clr_wr = '0;
    if (io_req_i.wr && io_req_i.addr == eint_pkg::IO_FLAGS_OFS)
    begin
      clr_wr[0] = io_req_i.wdata[eint_pkg::PEND_ZERO_BIT];
      clr_wr[1] = io_req_i.wdata[eint_pkg::PEND_ONE_BIT];
    end
  end

  // ****************************************
  // pending flags and vector requests
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      logic [1:0] code;
      assign code        = sense_i[2*g +: 2];
      // codes 00 and 01 both mean low level, so no code is left unused
      assign is_level[g] = (code == eint_pkg::SENSE_LOW) || (code == 2'b01);
      // edge_hit is forced low while the i/o clock is stopped
      assign edge_hit[g] = io_clk_run_i &&
        (((code == eint_pkg::SENSE_FALL) && prev_r[g] && !sync2_r[g]) ||
         ((code == eint_pkg::SENSE_RISE) && !prev_r[g] && sync2_r[g]));

      // set wins over any clear in the same cycle; a flag in level mode is
      // held clear as well as masked at read, so a switch back to edge
      // sense starts without a stale event
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          pend_r[g] <= 1'b0;
        else if (is_level[g])
          pend_r[g] <= 1'b0;
        else if (edge_hit[g])
          pend_r[g] <= 1'b1;
        else if (clr_wr[g] || ack_i[g])
          pend_r[g] <= 1'b0;
      end

      // a level request follows the pin itself; there is no flag behind it
      always_comb
      begin
        if (is_level[g])
          vec_req_o[g] = glob_en_i && src_en_i[g] && !sync2_r[g] && lvl_ok_r[g];
        else
          vec_req_o[g] = glob_en_i && src_en_i[g] && pend_r[g];
      end
    end
  endgenerate

  // ****************************************
  // watchdog-rate level sampling for wake
  // ****************************************
  // the level path reads the synchronised pin and is never gated by
  // io_clk_run_i, so a held low level is still seen in deep sleep
  // limitation: the tick comes from the core clock, so its period does
  // not drift with supply voltage as a real watchdog oscillator would
  localparam logic [7:0] WDT_LAST = 8'(eint_pkg::WDT_DIV_CYC - 1);

  // wake sequence: two agreeing ticks, then the startup delay
  typedef enum logic [1:0] {
    WK_IDLE  = 2'b00,
    WK_SEEN  = 2'b01,
    WK_START = 2'b10,
    WK_AWAKE = 2'b11
  } eint_wake_t;

  logic [7:0]      wdt_cnt_r;
  logic            wdt_tick;
  logic [NSRC-1:0] samp_r;
  logic [NSRC-1:0] armed;
  logic            first_ok;
  logic            second_ok;
  eint_wake_t      wake_st_r;
  logic [15:0]     su_cnt_r;
  logic            su_done;
  logic            wake_r;

  assign wdt_tick  = (wdt_cnt_r == WDT_LAST);
  assign armed     = is_level & src_en_i & ~sync2_r;
  assign first_ok  = wdt_tick && (armed != '0);
  assign second_ok = wdt_tick && ((samp_r & armed) != '0);
  // a preset of zero or one finishes at once rather than hanging
  assign su_done   = (su_cnt_r < 16'h0002);

  // free-running divider standing in for the watchdog oscillator
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wdt_cnt_r <= 8'h00;
    else if (wdt_tick)
      wdt_cnt_r <= 8'h00;
    else
      wdt_cnt_r <= wdt_cnt_r + 8'h01;
  end

  // two consecutive watchdog samples must both see the low level
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      samp_r <= '0;
    else if (wdt_tick)
      samp_r <= armed;
  end

  // ****************************************
  // wake sequence
  // ****************************************
  // leaving power-down restarts the sequence, so every sleep begins
  // with a fresh two-sample check
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wake_st_r <= WK_IDLE;
    else if (!power_down_i)
      wake_st_r <= WK_IDLE;
    else
    begin
      case (wake_st_r)
        WK_IDLE:
        begin
          if (first_ok)
            wake_st_r <= WK_SEEN;
        end
        WK_SEEN:
        begin
          if (second_ok)
            wake_st_r <= WK_START;
          else if (wdt_tick && !first_ok)
            wake_st_r <= WK_IDLE;
        end
        WK_START:
        begin
          if (su_done)
            wake_st_r <= WK_AWAKE;
        end
        WK_AWAKE:
          wake_st_r <= WK_AWAKE;
        default:
          wake_st_r <= WK_IDLE;
      endcase
    end
  end

  // the startup counter is loaded when the second sample agrees
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      su_cnt_r <= 16'h0000;
    else if (!power_down_i)
      su_cnt_r <= 16'h0000;
    else if (wake_st_r == WK_SEEN && second_ok)
      su_cnt_r <= STARTUP_CYC;
    else if (wake_st_r == WK_START && !su_done)
      su_cnt_r <= su_cnt_r - 16'h0001;
  end

  // wake stays up until the core leaves power-down
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wake_r <= 1'b0;
    else if (!power_down_i)
      wake_r <= 1'b0;
    else if (wake_st_r == WK_START && su_done)
      wake_r <= 1'b1;
  end

  // after a wake the level must still be present to raise the request;
  // outside power-down the level path is qualified from the cycle after power-down ends
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lvl_ok_r <= '1;
    else if (power_down_i)
      lvl_ok_r <= '0;
    else
      lvl_ok_r <= '1;
  end

  assign wake_o = wake_r;

  // ****************************************
  // register read
  // ****************************************
  // unmapped reads return zero so reads of several blocks can be ORed
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      io_rdata_o <= eint_pkg::FLAGS_RST;
    else if (io_req_i.rd && io_req_i.addr == eint_pkg::IO_FLAGS_OFS)
    begin
      io_rdata_o <= eint_pkg::FLAGS_RST;
      io_rdata_o[eint_pkg::PEND_ONE_BIT]  <= pend_r[1] & ~is_level[1];
      io_rdata_o[eint_pkg::PEND_ZERO_BIT] <= pend_r[0] & ~is_level[0];
    end
    else
      io_rdata_o <= eint_pkg::FLAGS_RST;
  end

  // hit is combinational so the core can steer its read mux in the access cycle
  assign io_hit_o  = (io_req_i.rd || io_req_i.wr) && io_req_i.addr == eint_pkg::IO_FLAGS_OFS;
  // the flags as software would read them, level-sensed ones masked
  assign pending_o = pend_r & ~is_level;

endmodule

// *** eint_pkg.sv ***
/*
  eint_pkg: constants and carrier types for the external pin interrupt block.
  assumes a single 100 MHz core clock and an 8-bit i/o register port.
*/
package eint_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] IO_FLAGS_OFS   = 6'h3a;
  localparam logic [7:0] DS_OFS_ADD     = 8'h20;
  localparam logic [7:0] DS_FLAGS_ADDR  = 8'h5a;
  localparam int         PEND_ONE_BIT   = 7;
  localparam int         PEND_ZERO_BIT  = 6;
  localparam logic [7:0] FLAGS_RST      = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         WDT_PERIOD_NS  = 1000;
  localparam int         WDT_DIV_CYC    = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         WAKE_SAMPLES   = 2;
  localparam logic [15:0] STARTUP_CYC_RST = 16'h0040;

  // ****************************************
  // sense codes
  // ****************************************
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eint_sense_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eint_io_req_t;

endpackage

// *** eint_checker.sv ***
/*
  eint_checker: port-level assertions on eint_ctrl.
  assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ps
module eint_checker #(
  parameter int NSRC = 2
) (
  input wire logic                   clk_i,        // clock
  input wire logic                   rst_b_i,      // reset, active low
  input wire logic [NSRC-1:0]        pin_i,        // pins
  input wire logic [2*NSRC-1:0]      sense_i,      // sense codes
  input wire logic [NSRC-1:0]        src_en_i,     // source enables
  input wire logic                   glob_en_i,    // global enable
  input wire logic                   io_clk_run_i, // i/o clock runs
  input wire logic                   power_down_i, // deep sleep
  input wire logic                   wake_o,       // wake request
  input wire eint_pkg::eint_io_req_t io_req_i,     // access
  input wire logic [NSRC-1:0]        ack_i,        // routine entry
  input wire logic [7:0]             io_rdata_o,   // read data
  input wire logic                   io_hit_o,     // flag hit
  input wire logic [NSRC-1:0]        vec_req_o,    // vector requests
  input wire logic [NSRC-1:0]        pending_o     // flags
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rq = io_req_i.rd || io_req_i.wr;
  // quiet pins: no edge can still be in the synchroniser
  sequence s_q; $stable(pin_i)[*4]; endsequence
  property p_hit; rq |-> io_hit_o == (io_req_i.addr == eint_pkg::IO_FLAGS_OFS); endproperty
  property p_rdz; io_req_i.rd && !io_hit_o |=> io_rdata_o == 8'h00; endproperty
  property p_low; io_rdata_o[5:0] == 6'h00; endproperty
  property p_msk; !(pending_o[0] && !sense_i[1]) && !(pending_o[1] && !sense_i[3]); endproperty
  property p_vec; vec_req_o != 0 |-> glob_en_i && (vec_req_o & ~src_en_i) == 0; endproperty
  property p_clr; s_q ##0 (io_hit_o && io_req_i.wr && io_req_i.wdata[6]) |=> !pending_o[0];
  endproperty
  property p_ack; s_q ##0 ack_i[1] |=> !pending_o[1]; endproperty
  property p_edg; $fell(pin_i[0]) && sense_i[1:0] == 2'b10 && io_clk_run_i
    |-> ##[1:4] pending_o[0]; endproperty
  property p_wak; !power_down_i |=> !wake_o; endproperty
  a_hit: assert property (p_hit) else $error("flag hit wrong");
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  a_low: assert property (p_low) else $error("unused bits set");
  a_msk: assert property (p_msk) else $error("level flag reads set");
  a_vec: assert property (p_vec) else $error("vector without enable");
  a_clr: assert property (p_clr) else $error("write one kept flag");
  a_ack: assert property (p_ack) else $error("entry kept flag");
  a_edg: assert property (p_edg) else $error("fall not flagged");
  a_wak: assert property (p_wak) else $error("wake outside power-down");
  c_vec: cover property (vec_req_o[1]);
  c_two: cover property (pending_o[0] && pending_o[1]);
  c_wr: cover property (io_hit_o && io_req_i.wr);
  c_wak: cover property (wake_o);
endmodule

bind eint_ctrl eint_checker #(.NSRC(NSRC)) i_eint_checker (
  .clk_i        (clk_i),
  .rst_b_i      (rst_b_i),
  .pin_i        (pin_i),
  .sense_i      (sense_i),
  .src_en_i     (src_en_i),
  .glob_en_i    (glob_en_i),
  .io_clk_run_i (io_clk_run_i),
  .power_down_i (power_down_i),
  .wake_o       (wake_o),
  .io_req_i     (io_req_i),
  .ack_i        (ack_i),
  .io_rdata_o   (io_rdata_o),
  .io_hit_o     (io_hit_o),
  .vec_req_o    (vec_req_o),
  .pending_o    (pending_o)
);

// *** eint_src.sv ***
/*
  eint_src: source on the two interrupt pins.
  assumes pins idle high; changes land just after a clock edge.
*/
`timescale 1ns/1ps
module eint_src (
  input  wire logic       clk_i, // clock
  output logic      [1:0] pin_o  // pin levels
);
  // ****************************************
  // drive
  // ****************************************
  initial pin_o = 2'h3;
  // a level is held until the next call, so wake can complete
  task automatic set(input logic [1:0] v);
    @(posedge clk_i);
    pin_o <= v;
  endtask
endmodule

// *** tb.sv ***
/*
  tb: scenarios for eint_ctrl driven through eint_src.
  assumes package, design, model and checker compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic                   clk_i, rst_b_i, glob_en_i, io_clk_run_i, power_down_i;
  logic                   io_hit_o, wake_o;
  logic [3:0]             sense_i;
  logic [1:0]             pin_i, src_en_i, ack_i, vec_req_o, pending_o;
  logic [7:0]             io_rdata_o;
  eint_pkg::eint_io_req_t io_req_i;
  int                     miscompares = 0;
  int                     tests_run = 0;
  eint_src i_eint_src (.clk_i(clk_i), .pin_o(pin_i));
  eint_ctrl #(.STARTUP_CYC(16'h0008)) i_eint_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .pin_i(pin_i), .sense_i(sense_i),
    .src_en_i(src_en_i), .glob_en_i(glob_en_i), .io_clk_run_i(io_clk_run_i),
    .power_down_i(power_down_i), .io_req_i(io_req_i), .ack_i(ack_i),
    .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o), .vec_req_o(vec_req_o),
    .wake_o(wake_o), .pending_o(pending_o));
  // ****************************************
  // helpers
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
    #1;
    ck({7'h00, io_hit_o}, {7'h00, a == eint_pkg::IO_FLAGS_OFS});
    @(posedge clk_i);
    io_req_i <= '0;
    #1;
  endtask
  task automatic rdk(input logic [7:0] e);
    acc(1'b0, eint_pkg::IO_FLAGS_OFS, 8'h00);
    ck(io_rdata_o, e);
  endtask
  task automatic pe(input logic [1:0] p, input logic [7:0] e);
    i_eint_src.set(p);
    cy(6);
    rdk(e);
  endtask
  task automatic en(input logic g, input logic [1:0] s, input logic [7:0] e);
    @(posedge clk_i);
    glob_en_i <= g;
    src_en_i <= s;
    cy(1);
    ck({6'h00, vec_req_o}, e);
  endtask
  task automatic results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_edge;
    rdk(eint_pkg::FLAGS_RST);
    acc(1'b0, 6'h13, 8'h00);
    ck(io_rdata_o, 8'h00);
    en(1'b1, 2'h3, 8'h00);
    pe(2'h1, 8'h00);
    pe(2'h3, 8'h80);
    pe(2'h2, 8'hc0);
    en(1'b1, 2'h1, 8'h01);
    en(1'b0, 2'h3, 8'h00);
    en(1'b1, 2'h3, 8'h03);
  endtask
  task automatic t_lvl;
    @(posedge clk_i);
    sense_i <= 4'hd;
    cy(6);
    ck({6'h00, pending_o}, 8'h02);
    ck({6'h00, vec_req_o}, 8'h03);
    pe(2'h3, 8'h80);
    ck({6'h00, vec_req_o}, 8'h02);
  endtask
  task automatic t_clr;
    @(posedge clk_i);
    sense_i <= 4'he;
    pe(2'h2, 8'hc0);
    acc(1'b1, eint_pkg::IO_FLAGS_OFS, 8'h40);
    rdk(8'h80);
    acc(1'b1, eint_pkg::IO_FLAGS_OFS, 8'h00);
    rdk(8'h80);
    @(posedge clk_i);
    ack_i <= 2'h2;
    @(posedge clk_i);
    ack_i <= 2'h0;
    rdk(8'h00);
  endtask
  task automatic t_wake;
    int n;
    @(posedge clk_i);
    io_clk_run_i <= 1'b0;
    pe(2'h3, 8'h00);
    pe(2'h2, 8'h00);
    @(posedge clk_i);
    sense_i <= 4'hc;
    power_down_i <= 1'b1;
    i_eint_src.set(2'h2);
    n = 0;
    while (wake_o !== 1'b1 && n < 500)
    begin
      cy(1);
      n++;
    end
    ck({7'h00, n >= eint_pkg::WDT_DIV_CYC && n < 500}, 8'h01);
    @(posedge clk_i);
    power_down_i <= 1'b0;
    io_clk_run_i <= 1'b1;
    cy(8);
    ck({6'h00, vec_req_o}, 8'h01);
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    glob_en_i = 1'b0;
    io_clk_run_i = 1'b1;
    power_down_i = 1'b0;
    sense_i = 4'he;
    src_en_i = 2'h0;
    ack_i = 2'h0;
    io_req_i = '0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_edge();
    t_lvl();
    t_clr();
    t_wake();
    results();
  end
  // the run needs well under 1000 cycles
  initial
  begin
    #20000;
    miscompares++;
    results();
  end
endmodule
